// ===== vram_serial_register_transfer_control_bench.sv
// Self-checking bench for the serial register transfer controller
`timescale 1ns/1ps
`default_nettype none
module vram_serial_register_transfer_control_bench;
	logic mclk_i = 1'b0, reset_n_i = 1'b0;
	logic cmd_valid_i = 1'b0, wr_valid_i = 1'b0, rd_ready_i = 1'b0;
	logic [1:0] cmd_op_i = 2'h0;
	logic [8:0] cmd_row_i = 9'h000, cmd_tap_i = 9'h000;
	logic [3:0] wr_data_i = 4'h0;
	logic cmd_ready_o, wr_ready_o, rd_valid_o, write_mode_o, row_n, col_n;
	logic trg_n, we_n, se_n, sc, oe;
	logic [3:0] rd_data_o, sd_o, sq, sio;
	logic [8:0] shift_pos_o, addr;
	logic [3:0] w [6];
	logic [8:0] tap, r1, r2;
	int fails = 0, n_compared = 0, cyc = 0, k;
	int seed = 32'h3c70660c;
	always #2.5 mclk_i = ~mclk_i;
	assign sio = oe ? sd_o : sq;
	vsrtc_host dut (.mclk_i, .reset_n_i, .cmd_valid_i, .cmd_ready_o,
		.cmd_op_i, .cmd_row_i, .cmd_tap_i, .wr_data_i, .wr_valid_i,
		.wr_ready_o, .rd_data_o, .rd_valid_o, .rd_ready_i, .write_mode_o,
		.shift_pos_o, .row_strobe_n_o(row_n), .col_strobe_n_o(col_n),
		.addr_o(addr), .transfer_output_enable_n_o(trg_n),
		.write_enable_n_o(we_n), .serial_port_enable_n_o(se_n),
		.serial_shift_clock_o(sc), .serial_io_pins_o(sd_o),
		.serial_io_pins_oe_o(oe), .serial_io_pins_i(sio));
	vsrtc_vram_model model (.row_n_i(row_n), .col_n_i(col_n), .addr_i(addr),
		.trg_n_i(trg_n), .we_n_i(we_n), .se_n_i(se_n), .sc_i(sc),
		.sd_i(sio), .sq_o(sq));
	function automatic logic [8:0] nxt(input logic [8:0] t, input int n);
		return 9'(t + n);
	endfunction
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [1:0] op, input logic [8:0] row, t);
		int n;
		cmd_op_i = op;
		cmd_row_i = row;
		cmd_tap_i = t;
		cmd_valid_i = 1'b1;
		n = 0;
		do begin
			@(negedge mclk_i);
			n++;
		end while (cmd_ready_o !== 1'b1 && n < 3000);
		cmd_valid_i = 1'b0;
		wr_valid_i = 1'b0;
		@(negedge mclk_i);
		if (n >= 3000) begin
			fails++;
			$display("MISMATCH %0t command never finished", $time);
		end
	endtask
	task automatic shift(input logic v, input logic [3:0] d);
		wr_valid_i = v;
		wr_data_i = d;
		cmd(2'h3, 9'h000, 9'h000);
	endtask
	task automatic pop(input logic [3:0] exp);
		int n;
		n = 0;
		while (rd_valid_o !== 1'b1 && n < 500) begin
			@(negedge mclk_i);
			n++;
		end
		chk({5'h00, rd_data_o}, {5'h00, exp});
		rd_ready_i = 1'b1;
		@(negedge mclk_i);
		rd_ready_i = 1'b0;
		@(negedge mclk_i);
	endtask
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			test_done;
		end
	end
	initial begin
		repeat (16) @(negedge mclk_i);
		reset_n_i = 1'b1;
		tap = 9'h1fe;
		r1 = 9'($random(seed));
		r2 = r1 ^ 9'h0a5;
		cmd(2'h0, 9'h000, tap);
		chk({8'h00, write_mode_o}, 9'h001);
		for (k = 0; k < 6; k++) begin
			w[k] = 4'($random(seed));
			shift(1'b1, w[k]);
			chk(shift_pos_o, nxt(tap, k + 1));
		end
		cmd(2'h1, r1, tap);
		chk({8'h00, write_mode_o}, 9'h001);
		cmd(2'h2, r1, tap);
		chk({8'h00, write_mode_o}, 9'h000);
		cmd(2'h1, r2, tap);
		cmd(2'h1, r2 ^ 9'h100, tap);
		chk({8'h00, write_mode_o}, 9'h000);
		cmd(2'h2, r2 ^ 9'h100, nxt(tap, 1));
		shift(1'b0, 4'h0);
		shift(1'b0, 4'h0);
		repeat (20) @(negedge mclk_i);
		pop(w[1]);
		pop(w[2]);
		for (k = 3; k < 6; k++) begin
			shift(1'b0, 4'h0);
			pop(w[k]);
		end
		test_done;
	end
endmodule
bind vsrtc_host vsrtc_host_chk u_chk (.mclk_i, .reset_n_i, .cmd_valid_i,
	.cmd_ready_o, .cmd_op_i, .cmd_tap_i, .write_mode_o, .shift_pos_o,
	.row_strobe_n_o, .transfer_output_enable_n_o, .serial_port_enable_n_o,
	.serial_shift_clock_o, .serial_io_pins_oe_o);
`default_nettype wire

// ===== vsrtc_buf_if.sv
// Interface carrying one valid/ready word stream
`timescale 1ns/1ps
`default_nettype none
interface vsrtc_buf_if #(parameter int W = 4);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== vsrtc_host.sv
// Controller driving the serial port and transfer cycles of a video DRAM
`timescale 1ns/1ps
`default_nettype none
module vsrtc_host (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire logic [1:0] cmd_op_i,
	input wire logic [8:0] cmd_row_i,
	input wire logic [8:0] cmd_tap_i,
	input wire logic [3:0] wr_data_i,
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	output logic [3:0] rd_data_o,
	output logic rd_valid_o,
	input wire logic rd_ready_i,
	output logic write_mode_o,
	output logic [8:0] shift_pos_o,
	output logic row_strobe_n_o,
	output logic col_strobe_n_o,
	output logic [8:0] addr_o,
	output logic transfer_output_enable_n_o,
	output logic write_enable_n_o,
	output logic serial_port_enable_n_o,
	output logic serial_shift_clock_o,
	output logic [3:0] serial_io_pins_o,
	output logic serial_io_pins_oe_o,
	input wire logic [3:0] serial_io_pins_i
);
	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	vsrtc_pkg::vsrtc_state_t state;
	vsrtc_pkg::vsrtc_cmd_t op;
	logic [7:0] cnt;
	logic [8:0] col;
	logic first_shift;
	logic [3:0] sio_meta;
	logic [3:0] sio_sync;
	logic rd_pend;

	vsrtc_buf_if #(.W(vsrtc_pkg::DATA_W)) in_b();
	vsrtc_buf_if #(.W(vsrtc_pkg::DATA_W)) out_b();

	vsrtc_skid_buf #(.W(vsrtc_pkg::DATA_W)) u_buf (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.in_if(in_b.snk),
		.out_if(out_b.src)
	);

	function automatic logic [7:0] half_len(input logic odd_first);
		half_len = odd_first ? 8'(vsrtc_pkg::ODD_HALF_CYC)
			: 8'(vsrtc_pkg::SC_HALF_CYC);
	endfunction

	// Receive path: sampled serial data into the buffer
	assign in_b.valid = rd_pend;
	assign in_b.data = sio_sync;
	assign out_b.ready = !rd_valid_o || rd_ready_i;

	logic shift_go;
	assign shift_go = (op == vsrtc_pkg::VSRTC_CMD_SHIFT) &&
		(write_mode_o ? wr_valid_i : in_b.ready);

	// Serial clock rises only after its data have stood a cycle
	logic go_q;
	logic sc_fire;
	logic mode_edge;
	assign sc_fire = (state == vsrtc_pkg::VSRTC_SC_LOW) &&
		(cnt == vsrtc_pkg::CNT_ZERO) && shift_go && go_q;
	// Mode follows the transfer strobe's rise
	assign mode_edge = (state == vsrtc_pkg::VSRTC_COL_LOW) &&
		(cnt == vsrtc_pkg::CNT_ZERO);

	// ---------------------------------------------------------------
	// Pin synchroniser
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sio_meta <= 4'h0;
			sio_sync <= 4'h0;
		end else begin
			sio_meta <= serial_io_pins_i;
			sio_sync <= sio_meta;
		end
	end

	// ---------------------------------------------------------------
	// Cycle sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= vsrtc_pkg::VSRTC_IDLE;
			op <= vsrtc_pkg::VSRTC_CMD_SHIFT;
			cnt <= vsrtc_pkg::CNT_ZERO;
			col <= 9'h000;
			cmd_ready_o <= 1'b0;
			row_strobe_n_o <= 1'b1;
			col_strobe_n_o <= 1'b1;
			addr_o <= 9'h000;
			transfer_output_enable_n_o <= 1'b1;
			write_enable_n_o <= 1'b1;
			serial_port_enable_n_o <= 1'b1;
			serial_shift_clock_o <= 1'b0;
			wr_ready_o <= 1'b0;
			rd_pend <= 1'b0;
			go_q <= 1'b0;
		end else begin
			cmd_ready_o <= 1'b0;
			wr_ready_o <= 1'b0;
			go_q <= shift_go && (state == vsrtc_pkg::VSRTC_SC_LOW);
			if (rd_pend && in_b.ready) begin
				rd_pend <= 1'b0;
			end
			if (cnt != vsrtc_pkg::CNT_ZERO) begin
				cnt <= cnt - 8'h01;
			end
			case (state)
			vsrtc_pkg::VSRTC_IDLE: begin
				serial_port_enable_n_o <= 1'b1;
				if (cmd_valid_i && !cmd_ready_o) begin
					op <= vsrtc_pkg::vsrtc_cmd_t'(cmd_op_i);
					addr_o <= cmd_row_i;
					col <= cmd_tap_i;
					cnt <= 8'(vsrtc_pkg::SC_QUIET_CYC);
					state <= (cmd_op_i == 2'(vsrtc_pkg::VSRTC_CMD_SHIFT))
						? vsrtc_pkg::VSRTC_SC_LOW
						: vsrtc_pkg::VSRTC_ROW_SETUP;
					if (cmd_op_i == 2'(vsrtc_pkg::VSRTC_CMD_SHIFT)) begin
						cnt <= vsrtc_pkg::CNT_ZERO;
						serial_port_enable_n_o <= 1'b0;
					end
				end
			end
			vsrtc_pkg::VSRTC_ROW_SETUP: begin
				// Serial clock held low; every transfer, mode cycle too,
				// drops the transfer strobe
				serial_shift_clock_o <= 1'b0;
				transfer_output_enable_n_o <= 1'b0;
				write_enable_n_o <= (op == vsrtc_pkg::VSRTC_CMD_MEM2REG);
				// Serial enable high at row fall marks the mode cycle
				serial_port_enable_n_o <= (op == vsrtc_pkg::VSRTC_CMD_WMODE);
				if (cnt == vsrtc_pkg::CNT_ZERO) begin
					row_strobe_n_o <= 1'b0;
					cnt <= 8'(vsrtc_pkg::STROBE_CYC);
					state <= vsrtc_pkg::VSRTC_ROW_LOW;
				end
			end
			vsrtc_pkg::VSRTC_ROW_LOW: begin
				// Column address settles long before the column strobe
				addr_o <= col;
				if (cnt == vsrtc_pkg::CNT_ZERO) begin
					col_strobe_n_o <= 1'b0;
					cnt <= 8'(vsrtc_pkg::STROBE_CYC);
					state <= vsrtc_pkg::VSRTC_COL_LOW;
				end
			end
			vsrtc_pkg::VSRTC_COL_LOW: begin
				if (cnt == vsrtc_pkg::CNT_ZERO) begin
					// Stays high until the next transfer
					transfer_output_enable_n_o <= 1'b1;
					cnt <= 8'(vsrtc_pkg::STROBE_CYC);
					state <= vsrtc_pkg::VSRTC_STROBE_RISE;
				end
			end
			vsrtc_pkg::VSRTC_STROBE_RISE: begin
				if (cnt == vsrtc_pkg::CNT_ZERO) begin
					row_strobe_n_o <= 1'b1;
					col_strobe_n_o <= 1'b1;
					write_enable_n_o <= 1'b1;
					cnt <= 8'(vsrtc_pkg::STROBE_CYC);
					state <= vsrtc_pkg::VSRTC_ROW_HIGH;
				end
			end
			vsrtc_pkg::VSRTC_ROW_HIGH: begin
				serial_port_enable_n_o <= 1'b1;
				if (cnt == vsrtc_pkg::CNT_ZERO) begin
					cmd_ready_o <= 1'b1;
					state <= vsrtc_pkg::VSRTC_IDLE;
				end
			end
			vsrtc_pkg::VSRTC_SC_LOW: begin
				if (sc_fire) begin
					serial_shift_clock_o <= 1'b1;
					cnt <= half_len(first_shift && col[0]);
					wr_ready_o <= write_mode_o;
					state <= vsrtc_pkg::VSRTC_SC_HIGH;
				end
			end
			vsrtc_pkg::VSRTC_SC_HIGH: begin
				if (cnt == vsrtc_pkg::CNT_ZERO) begin
					serial_shift_clock_o <= 1'b0;
					rd_pend <= !write_mode_o;
					cnt <= half_len(first_shift && col[0]);
					state <= vsrtc_pkg::VSRTC_ROW_HIGH;
				end
			end
			default: begin
				state <= vsrtc_pkg::VSRTC_IDLE;
			end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Mode tracking and shift position
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			write_mode_o <= 1'b0;
			first_shift <= 1'b1;
			shift_pos_o <= 9'h000;
		end else if (mode_edge) begin
			case (op)
			vsrtc_pkg::VSRTC_CMD_WMODE: write_mode_o <= 1'b1;
			vsrtc_pkg::VSRTC_CMD_MEM2REG: write_mode_o <= 1'b0;
			default: write_mode_o <= write_mode_o;
			endcase
			shift_pos_o <= col;
			first_shift <= 1'b1;
		end else if (sc_fire) begin
			shift_pos_o <= shift_pos_o + 9'h001;
			first_shift <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Serial data pins
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			serial_io_pins_o <= 4'h0;
			serial_io_pins_oe_o <= 1'b0;
			rd_data_o <= 4'h0;
			rd_valid_o <= 1'b0;
		end else begin
			// Released in the cycle that a load leaves write mode
			serial_io_pins_oe_o <= write_mode_o && !(mode_edge &&
				op == vsrtc_pkg::VSRTC_CMD_MEM2REG);
			if (state == vsrtc_pkg::VSRTC_SC_LOW && shift_go &&
				write_mode_o) begin
				serial_io_pins_o <= wr_data_i;
			end
			if (out_b.valid && out_b.ready) begin
				rd_data_o <= out_b.data;
				rd_valid_o <= 1'b1;
			end else if (rd_ready_i) begin
				rd_valid_o <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ===== vsrtc_host_asserts.sv
// Concurrent checks on the controller's pins and status ports
`timescale 1ns/1ps
`default_nettype none
module vsrtc_host_chk (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_ready_o,
	input wire logic [1:0] cmd_op_i,
	input wire logic [8:0] cmd_tap_i,
	input wire logic write_mode_o,
	input wire logic [8:0] shift_pos_o,
	input wire logic row_strobe_n_o,
	input wire logic transfer_output_enable_n_o,
	input wire logic serial_port_enable_n_o,
	input wire logic serial_shift_clock_o,
	input wire logic serial_io_pins_oe_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	// ---------------------------------------------------------------
	// End of a transfer of one kind
	// ---------------------------------------------------------------
	sequence s_trg_end(logic [1:0] op);
		$rose(transfer_output_enable_n_o) && cmd_op_i == op;
	endsequence
	a_wmode_se_high: assert property ($fell(row_strobe_n_o) && cmd_op_i == 2'h0 |-> serial_port_enable_n_o)
		else $error("serial enable low at row fall of mode cycle");
	a_r2m_sc_quiet: assert property (!row_strobe_n_o && !transfer_output_enable_n_o && cmd_op_i == 2'h1 |-> $stable(serial_shift_clock_o))
		else $error("serial clock moved in register to memory transfer");
	a_load_sc_quiet: assert property (s_trg_end(2'h2) |-> !serial_shift_clock_o || ($past(serial_shift_clock_o) && $past(serial_shift_clock_o, 2)))
		else $error("serial clock rose just before strobe rise");
	a_load_read_mode: assert property (s_trg_end(2'h2) |-> ##[1:2] !write_mode_o)
		else $error("load did not leave write mode");
	a_wmode_enter: assert property (s_trg_end(2'h0) |-> ##[1:2] write_mode_o)
		else $error("mode cycle did not enter write mode");
	a_r2m_keep_mode: assert property (cmd_valid_i && cmd_op_i == 2'h1 |=> $stable(write_mode_o))
		else $error("register to memory changed the mode");
	a_oe_write_only: assert property (serial_io_pins_oe_o |-> write_mode_o)
		else $error("serial pins driven outside write mode");
	a_pos_step_one: assert property ($changed(shift_pos_o) && cmd_op_i == 2'h3 |-> shift_pos_o == $past(shift_pos_o) + 9'h001)
		else $error("pointer did not advance by one");
	a_tap_latched: assert property (cmd_ready_o && cmd_valid_i && cmd_op_i != 2'h3 |-> shift_pos_o == cmd_tap_i)
		else $error("pointer not at tap after transfer");
endmodule
`default_nettype wire

// ===== vsrtc_pkg.sv
// Package of constants and types for the serial register transfer controller
// Overview of operation
// - Hold serial enable high at row fall (the code does so only for the mode cycle; the other transfers hold it low)
// - No serial clock edges during register-to-memory
// - Repeat writes: first write, read back, then more
// - First bit needs a serial clock rise
// - Write-mode cycle before shifting data in
// - Transfer strobe high at row fall when serial
// - Odd tap: first clock period at least 70 ns
// - Load before reading serial data out
// - No serial clock rise 10 ns before strobe rise
package vsrtc_pkg;
	// ---------------------------------------------------------------
	// Widths
	// ---------------------------------------------------------------
	localparam int ADDR_W = 9;
	localparam int DATA_W = 4;
	localparam int TAP_MAX = 511;
	// ---------------------------------------------------------------
	// Timing, in ns and in 5 ns cycles
	// ---------------------------------------------------------------
	localparam int CLK_NS = 5;
	localparam int ODD_TAP_PERIOD_NS = 70;
	localparam int SC_QUIET_NS = 10;
	localparam int STROBE_NS = 120;
	localparam int ODD_HALF_CYC = (ODD_TAP_PERIOD_NS / 2 + CLK_NS - 1) / CLK_NS;
	localparam int SC_QUIET_CYC = (SC_QUIET_NS + CLK_NS - 1) / CLK_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SC_HALF_CYC = 4;
	localparam logic [7:0] CNT_ZERO = 8'h00;
	// ---------------------------------------------------------------
	// Commands and states
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		VSRTC_CMD_WMODE,
		VSRTC_CMD_REG2MEM,
		VSRTC_CMD_MEM2REG,
		VSRTC_CMD_SHIFT
	} vsrtc_cmd_t;
	typedef enum {
		VSRTC_IDLE,
		VSRTC_ROW_SETUP,
		VSRTC_ROW_LOW,
		VSRTC_COL_LOW,
		VSRTC_STROBE_RISE,
		VSRTC_ROW_HIGH,
		VSRTC_SC_HIGH,
		VSRTC_SC_LOW
	} vsrtc_state_t;
endpackage

// ===== vsrtc_skid_buf.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module vsrtc_skid_buf #(
	parameter int W = 4
) (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	vsrtc_buf_if.snk in_if,
	vsrtc_buf_if.src out_if
);
	logic [W-1:0] mem [2];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] count;
	logic push;
	logic pop;

	assign in_if.ready = (count != 2'h2);
	assign out_if.valid = (count != 2'h0);
	assign out_if.data = mem[rd_ptr];
	assign push = in_if.valid && in_if.ready;
	assign pop = out_if.valid && out_if.ready;

	always_ff @(posedge mclk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_if.data;
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr <= ~wr_ptr;
			end
			if (pop) begin
				rd_ptr <= ~rd_ptr;
			end
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule
`default_nettype wire

// ===== vsrtc_vram_model.sv
// Behavioural model of the video memory's serial port and transfers
`timescale 1ns/1ps
`default_nettype none
module vsrtc_vram_model (
	input wire logic row_n_i,
	input wire logic col_n_i,
	input wire logic [8:0] addr_i,
	input wire logic trg_n_i,
	input wire logic we_n_i,
	input wire logic se_n_i,
	input wire logic sc_i,
	input wire logic [3:0] sd_i,
	output logic [3:0] sq_o
);
	logic [3:0] serial_access_store [512];
	logic [3:0] mem [logic [17:0]];
	logic [8:0] row, ptr;
	logic trg_l, we_l, se_l, wmode;
	logic [3:0] sq;
	int i;
	initial begin
		for (i = 0; i < 512; i++) serial_access_store[i] = 4'h0;
		wmode = 1'b0;
		ptr = 9'h000;
		sq = 4'h0;
	end
	always @(negedge row_n_i) begin
		row = addr_i;
		trg_l = trg_n_i;
		we_l = we_n_i;
		se_l = se_n_i;
	end
	always @(negedge col_n_i) if (!row_n_i) ptr = addr_i;
	// Random port is never driven here, so it stays off throughout
	always @(posedge trg_n_i) if (!row_n_i && !trg_l) begin
		if (we_l) begin
			for (i = 0; i < 512; i++) serial_access_store[i] = mem[{row, 9'(i)}];
			wmode = 1'b0;
		end else if (se_l) begin
			wmode = 1'b1;
		end else begin
			for (i = 0; i < 512; i++) mem[{row, 9'(i)}] = serial_access_store[i];
		end
	end
	always @(posedge sc_i) if (!se_n_i) begin
		if (wmode) serial_access_store[ptr] = sd_i;
		else sq = serial_access_store[ptr];
		ptr = ptr + 9'h001;
	end
	// Disabled outputs show no stale word
	assign sq_o = (!wmode && !se_n_i) ? sq : ~sq;
endmodule
`default_nettype wire
